// *** src/vgm_graphics_map.sv ***
// graphics mapping register bank with frame-buffer window decode and write masking
// Behaviour
// - map field picks the cpu frame-buffer window
// - chain bit swaps address bit zero, odd/even planes, only without packed or linear
// - misc and ignore upper nibbles read zero
// - ignore bits gate read-mode-1 compare only
// - zero mask bit keeps latch bit on legacy range write
// - mask hits all planes of legacy range writes after upstream data ops
// - every frame-buffer read reloads the read latches
// - local-memory bit only when paged, bypass, vga buffer
// - amc bit 3 picks vga buffer or memory map
// - packed bit forces packed translation, map still selects
// - paged address uses page bits above cpu bits
// - no bypass: vga translation, only paging pages a0000
// - packed or linear bypasses vga, only a0000 paged
// - legacy range no table no prefetch, graphics prefetches
// - page selector chooses 64-kb window, resets zero
// - twelve scratch bytes at 14h-1fh, reset zero, inert
// - registers reached by index then data port 3cfh
`timescale 1ns/10ps
module vgm_graphics_map
  import vgm_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  // register port
  input  wire logic             ioWrite,
  input  wire logic             ioRead,
  input  wire logic [15:0]      ioAddr,
  input  wire logic [7:0]       ioWrData,
  output logic      [7:0]       ioRdData,
  output logic                  ioRdValid,
  // frame-buffer request from the cpu side
  input  wire logic             fbReq,
  input  wire logic             fbWe,
  input  wire logic [19:0]      fbAddrIn,
  input  wire logic             gfxRangeIn,
  input  wire logic             prefetchDisable,
  input  wire logic [31:0]      fbWrPreMask,
  input  wire logic [3:0]       seqPlaneMask,
  // plane read return and read-mode settings held elsewhere
  input  wire logic             planeRdValid,
  input  wire logic [31:0]      planeRdData,
  input  wire logic             readModeOne,
  input  wire logic [1:0]       readPlaneSel,
  input  wire logic [3:0]       colorCompare,
  // translated request towards memory
  output logic                  fbGo,
  output logic                  fbWrite,
  output logic      [FB_AW-1:0] fbAddrOut,
  output logic      [3:0]       fbPlaneEn,
  output logic      [31:0]      fbWrData,
  output logic                  fbVgaXlate,
  output logic                  fbPaged,
  output logic                  fbToLocal,
  output logic                  fbMemMap,
  output logic                  fbPackedXlate,
  output logic                  fbNeedTable,
  output logic                  fbPrefetch,
  // cpu read return
  output logic      [7:0]       cpuRdData,
  output logic                  cpuRdValid,
  output logic                  graphicsMode
);

  // true when an index falls in the scratch range
  function automatic logic isScratch(input logic [7:0] idx);
    return (idx >= IDX_SCR_FIRST) && (idx <= IDX_SCR_LAST);
  endfunction : isScratch

  // true when a cpu address lies in the window the map field selects
  function automatic logic windowHit(input vgm_map_e mode, input logic [19:0] a);
    logic hit;
    hit = 1'b0;
    unique case (mode)
      MAP_A0_BF: hit = (a[19:17] == SEG_A_TO_B);
      MAP_A0:    hit = (a[19:16] == SEG_A);
      MAP_B0:    hit = (a[19:15] == SEG_B0);
      MAP_B8:    hit = (a[19:15] == SEG_B8);
    endcase
    return hit;
  endfunction : windowHit

  logic [7:0]        indexReg;
  logic [7:0]        miscMap;
  logic [7:0]        colorIgnore;
  logic [7:0]        writeBitMask;
  logic [7:0]        addrMapCtl;
  logic [7:0]        pageSel;
  logic [31:0]       readLatch;
  logic              rdPend;
  logic [7:0]        rdIdx;
  logic [7:0]        scrRdData;
  logic              dataWr;
  logic              dataRd;
  logic [SCR_AW-1:0] scrAddr;
  logic [7:0]        scrOffset;

  // every access to the data port goes through the index first
  assign dataWr    = ioWrite && (ioAddr == IO_DATA_ADDR);
  assign dataRd    = ioRead && (ioAddr == IO_DATA_ADDR);
  assign scrOffset = indexReg - IDX_SCR_FIRST;
  assign scrAddr   = scrOffset[SCR_AW-1:0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      indexReg <= INDEX_RESET;
    end else if (ioWrite && (ioAddr == IO_INDEX_ADDR)) begin
      indexReg <= ioWrData;
    end
  end

  // register writes; reserved positions never store
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      miscMap      <= MISC_RESET;
      colorIgnore  <= IGNORE_RESET;
      writeBitMask <= BITMASK_RESET;
      addrMapCtl   <= AMC_RESET;
      pageSel      <= PAGE_RESET;
    end else if (dataWr) begin
      unique case (indexReg)
        IDX_MISC:    miscMap      <= ioWrData & MISC_WR_MASK;
        IDX_IGNORE:  colorIgnore  <= ioWrData & IGNORE_WR_MASK;
        IDX_BITMASK: writeBitMask <= ioWrData;
        IDX_AMC:     addrMapCtl   <= ioWrData & AMC_WR_MASK;
        IDX_PAGE:    pageSel      <= ioWrData;
        default:     ;
      endcase
    end
  end

  // scratch bytes feed nothing but the read path
  vgm_scratch_mem uScratch (
    .clk    (clk),
    .rst_n  (rst_n),
    .we     (dataWr && isScratch(indexReg)),
    .wrAddr (scrAddr),
    .wrData (ioWrData),
    .rdAddr (scrAddr),
    .rdData (scrRdData)
  );

  // reads take two cycles so the scratch memory output stays registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdPend <= 1'b0;
      rdIdx  <= INDEX_RESET;
    end else begin
      rdPend <= dataRd || (ioRead && (ioAddr == IO_INDEX_ADDR));
      rdIdx  <= indexReg;
    end
  end

  logic       rdIsIndex;
  logic [7:0] next_ioRdData;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdIsIndex <= 1'b0;
    end else begin
      rdIsIndex <= ioRead && (ioAddr == IO_INDEX_ADDR);
    end
  end

  always_comb begin
    next_ioRdData = 8'h00;
    if (rdIsIndex) begin
      next_ioRdData = indexReg;
    end else if (isScratch(rdIdx)) begin
      next_ioRdData = scrRdData;
    end else begin
      unique case (rdIdx)
        IDX_MISC:    next_ioRdData = miscMap & MISC_WR_MASK;
        IDX_IGNORE:  next_ioRdData = colorIgnore & IGNORE_WR_MASK;
        IDX_BITMASK: next_ioRdData = writeBitMask;
        IDX_AMC:     next_ioRdData = addrMapCtl & AMC_WR_MASK;
        IDX_PAGE:    next_ioRdData = pageSel;
        default:     next_ioRdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ioRdData  <= 8'h00;
      ioRdValid <= 1'b0;
    end else begin
      ioRdValid <= rdPend;
      ioRdData  <= rdPend ? next_ioRdData : 8'h00;
    end
  end

  // frame-buffer address decode
  vgm_map_e         mapMode;
  logic             legacyHit;
  logic             inSegA;
  logic             xlateOff;
  logic             pageOn;
  logic             chainOn;
  logic [16:0]      winOffset;
  logic [16:0]      chainOffset;
  logic [FB_AW-1:0] next_addr;
  logic [3:0]       next_planes;

  always_comb begin
    mapMode   = vgm_map_e'(miscMap[MISC_MAP_LSB +: 2]);
    legacyHit = windowHit(mapMode, fbAddrIn);
    inSegA    = (fbAddrIn[19:16] == SEG_A);
    // packed or linear drops vga translation on every legacy range
    xlateOff  = addrMapCtl[AMC_LINEAR_BIT] | addrMapCtl[AMC_PACKED_BIT];
    // only the a0000 range is ever paged; b0 and b8 never
    pageOn    = addrMapCtl[AMC_PAGE_BIT] & inSegA;
    chainOn   = miscMap[MISC_CHAIN_BIT] & ~xlateOff;
    winOffset = 17'h00000;
    unique case (mapMode)
      MAP_A0_BF:      winOffset = fbAddrIn[16:0];
      MAP_A0:         winOffset = {1'b0, fbAddrIn[15:0]};
      MAP_B0, MAP_B8: winOffset = {2'b00, fbAddrIn[14:0]};
    endcase
    chainOffset = winOffset;
    if (chainOn) begin
      // bit zero picks the plane pair, so a high bit takes its place
      chainOffset[0]              = winOffset[CHAIN_SWAP_BIT];
      chainOffset[CHAIN_SWAP_BIT] = winOffset[0];
    end
    if (pageOn) begin
      next_addr = {pageSel[PAGE_BITS-1:0], chainOffset[15:2], chainOffset[1:0]};
    end else begin
      next_addr = {6'h00, chainOffset};
    end
    if (xlateOff) begin
      next_planes = ALL_PLANES;
    end else if (chainOn) begin
      next_planes = winOffset[0] ? ODD_PLANES : EVEN_PLANES;
    end else begin
      next_planes = seqPlaneMask;
    end
  end

  // bit mask merge against the latches, identical for every plane
  logic [31:0] maskedWr;
  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++) begin : gPlane
      assign maskedWr[gp*8 +: 8] = (fbWrPreMask[gp*8 +: 8] & writeBitMask) |
                                   (readLatch[gp*8 +: 8] & ~writeBitMask);
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fbGo          <= 1'b0;
      fbWrite       <= 1'b0;
      fbAddrOut     <= '0;
      fbPlaneEn     <= 4'h0;
      fbWrData      <= 32'h00000000;
      fbVgaXlate    <= 1'b0;
      fbPaged       <= 1'b0;
      fbToLocal     <= 1'b0;
      fbMemMap      <= 1'b0;
      fbPackedXlate <= 1'b0;
      fbNeedTable   <= 1'b0;
      fbPrefetch    <= 1'b0;
    end else begin
      fbGo    <= fbReq && (gfxRangeIn || legacyHit);
      fbWrite <= fbReq && fbWe && (gfxRangeIn || legacyHit);
      if (fbReq && gfxRangeIn) begin
        // aperture accesses go through the table and may prefetch
        fbAddrOut     <= {3'h0, fbAddrIn};
        fbPlaneEn     <= ALL_PLANES;
        fbWrData      <= fbWrPreMask;
        fbVgaXlate    <= 1'b0;
        fbPaged       <= 1'b0;
        fbToLocal     <= 1'b0;
        fbMemMap      <= 1'b0;
        fbPackedXlate <= 1'b0;
        fbNeedTable   <= 1'b1;
        fbPrefetch    <= ~prefetchDisable;
      end else if (fbReq && legacyHit) begin
        fbAddrOut     <= next_addr;
        fbPlaneEn     <= next_planes;
        fbWrData      <= maskedWr;
        fbVgaXlate    <= ~xlateOff;
        fbPaged       <= pageOn;
        fbToLocal     <= pageOn & xlateOff & ~addrMapCtl[AMC_MEMMAP_BIT] &
                         addrMapCtl[AMC_LOCAL_BIT];
        fbMemMap      <= addrMapCtl[AMC_MEMMAP_BIT];
        fbPackedXlate <= addrMapCtl[AMC_PACKED_BIT];
        fbNeedTable   <= 1'b0;
        fbPrefetch    <= 1'b0;
      end
    end
  end

  // read latches and the read-mode-1 compare
  logic [7:0] cmpResult;
  genvar gb;
  generate
    for (gb = 0; gb < 8; gb++) begin : gCmp
      logic [3:0] column;
      assign column = {planeRdData[24+gb], planeRdData[16+gb],
                       planeRdData[8+gb], planeRdData[gb]};
      // excluded planes always count as matching
      assign cmpResult[gb] = &(~colorIgnore[3:0] | ~(column ^ colorCompare));
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readLatch <= 32'h00000000;
    end else if (planeRdValid) begin
      readLatch <= planeRdData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpuRdData  <= 8'h00;
      cpuRdValid <= 1'b0;
    end else begin
      cpuRdValid <= planeRdValid;
      if (planeRdValid) begin
        // ignore bits matter only in read mode 1
        cpuRdData <= readModeOne ? cmpResult : planeRdData[readPlaneSel*8 +: 8];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      graphicsMode <= 1'b0;
    end else begin
      graphicsMode <= miscMap[MISC_GFX_BIT];
    end
  end

endmodule : vgm_graphics_map

// *** src/vgm_pkg.sv ***
// package: constants and types for the graphics mapping register bank
package vgm_pkg;

  // register port addresses (same value for i/o and memory offset)
  localparam logic [15:0] IO_INDEX_ADDR  = 16'h03ce;
  localparam logic [15:0] IO_DATA_ADDR   = 16'h03cf;

  // register indexes
  localparam logic [7:0]  IDX_MISC       = 8'h06;
  localparam logic [7:0]  IDX_IGNORE     = 8'h07;
  localparam logic [7:0]  IDX_BITMASK    = 8'h08;
  localparam logic [7:0]  IDX_AMC        = 8'h10;
  localparam logic [7:0]  IDX_PAGE       = 8'h11;
  localparam logic [7:0]  IDX_SCR_FIRST  = 8'h14;
  localparam logic [7:0]  IDX_SCR_LAST   = 8'h1f;
  localparam int          SCR_COUNT      = 12;
  localparam int          SCR_AW         = 4;

  // writable bits; all others read as zero
  localparam logic [7:0]  MISC_WR_MASK   = 8'h0f;
  localparam logic [7:0]  IGNORE_WR_MASK = 8'h0f;
  localparam logic [7:0]  AMC_WR_MASK    = 8'h1f;

  // reset values
  localparam logic [7:0]  INDEX_RESET    = 8'h00;
  localparam logic [7:0]  MISC_RESET     = 8'h00;
  localparam logic [7:0]  IGNORE_RESET   = 8'h00;
  localparam logic [7:0]  BITMASK_RESET  = 8'hff;
  localparam logic [7:0]  AMC_RESET      = 8'h00;
  localparam logic [7:0]  PAGE_RESET     = 8'h00;
  localparam logic [7:0]  SCR_RESET      = 8'h00;

  // field positions
  localparam int          MISC_GFX_BIT   = 0;
  localparam int          MISC_CHAIN_BIT = 1;
  localparam int          MISC_MAP_LSB   = 2;
  localparam int          AMC_PAGE_BIT   = 0;
  localparam int          AMC_LINEAR_BIT = 1;
  localparam int          AMC_PACKED_BIT = 2;
  localparam int          AMC_MEMMAP_BIT = 3;
  localparam int          AMC_LOCAL_BIT  = 4;

  // cpu address windows (upper address bits of a 20-bit real-mode address)
  localparam logic [2:0]  SEG_A_TO_B     = 3'b101;
  localparam logic [3:0]  SEG_A          = 4'ha;
  localparam logic [4:0]  SEG_B0         = 5'b10110;
  localparam logic [4:0]  SEG_B8         = 5'b10111;
  localparam int          CHAIN_SWAP_BIT = 16;
  localparam int          PAGE_BITS      = 7;
  localparam int          FB_AW          = 23;

  localparam logic [3:0]  EVEN_PLANES    = 4'b0101;
  localparam logic [3:0]  ODD_PLANES     = 4'b1010;
  localparam logic [3:0]  ALL_PLANES     = 4'hf;

  typedef enum logic [1:0] {
    MAP_A0_BF,
    MAP_A0,
    MAP_B0,
    MAP_B8
  } vgm_map_e;

endpackage : vgm_pkg

// *** src/vgm_scratch_mem.sv ***
// scratch flag storage: twelve bytes with registered read data
`timescale 1ns/10ps
module vgm_scratch_mem
  import vgm_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              we,
  input  wire logic [SCR_AW-1:0] wrAddr,
  input  wire logic [7:0]        wrData,
  input  wire logic [SCR_AW-1:0] rdAddr,
  output logic      [7:0]        rdData
);

  logic [7:0] mem [SCR_COUNT];

  // flops rather than ram so that every byte clears on reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < SCR_COUNT; i++) begin
        mem[i] <= SCR_RESET;
      end
    end else if (we && (int'(wrAddr) < SCR_COUNT)) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= SCR_RESET;
    end else if (int'(rdAddr) < SCR_COUNT) begin
      rdData <= mem[rdAddr];
    end else begin
      rdData <= 8'h00;
    end
  end

endmodule : vgm_scratch_mem

// *** verification/vgm_graphics_map_chk.sv ***
// assertion checker for the graphics mapping register bank
`timescale 1ns/10ps
module vgm_graphics_map_chk
  import vgm_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ioRead,
  input wire logic [15:0] ioAddr,
  input wire logic        ioRdValid,
  input wire logic [7:0]  ioRdData,
  input wire logic        fbReq,
  input wire logic        fbWe,
  input wire logic [19:0] fbAddrIn,
  input wire logic        gfxRangeIn,
  input wire logic        prefetchDisable,
  input wire logic        planeRdValid,
  input wire logic        cpuRdValid,
  input wire logic        fbGo,
  input wire logic        fbWrite,
  input wire logic        fbPaged,
  input wire logic        fbPackedXlate,
  input wire logic        fbVgaXlate,
  input wire logic        fbNeedTable,
  input wire logic        fbPrefetch
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence dataRead;
    ioRead && ioAddr == IO_DATA_ADDR;
  endsequence
  sequence readAnswer;
    ##2 ioRdValid;
  endsequence

  rd_answer_a: assert property (dataRead |-> readAnswer)
    else $error("data port read not answered after two cycles");
  rd_quiet_a: assert property (!ioRdValid |-> ioRdData == 8'h00)
    else $error("read data not zero outside an answer");
  window_miss_a: assert property (fbReq && !gfxRangeIn && fbAddrIn[19:17] != SEG_A_TO_B
    |=> !fbGo)
    else $error("access outside every window was issued");
  aperture_go_a: assert property (fbReq && gfxRangeIn |=> fbGo && fbNeedTable
    && fbWrite == $past(fbWe) && fbPrefetch != $past(prefetchDisable))
    else $error("aperture access qualifiers wrong");
  legacy_nofetch_a: assert property (fbGo && !fbNeedTable |-> !fbPrefetch)
    else $error("legacy access prefetched");
  b_unpaged_a: assert property (fbReq && !gfxRangeIn && fbAddrIn[19:16] == 4'hb
    |=> !fbGo || !fbPaged)
    else $error("b range access was paged");
  latch_return_a: assert property (planeRdValid |=> cpuRdValid)
    else $error("plane return not passed to the cpu");
  packed_bypass_a: assert property (fbGo && !fbNeedTable && fbPackedXlate
    |-> !fbVgaXlate)
    else $error("packed access kept vga translation");
endmodule : vgm_graphics_map_chk

bind vgm_graphics_map vgm_graphics_map_chk u_chk (.clk, .rst_n, .ioRead, .ioAddr,
  .ioRdValid, .ioRdData, .fbReq, .fbWe, .fbAddrIn, .gfxRangeIn, .prefetchDisable,
  .planeRdValid, .cpuRdValid, .fbGo, .fbWrite, .fbPaged, .fbPackedXlate, .fbVgaXlate,
  .fbNeedTable, .fbPrefetch);

// *** verification/vgm_plane_model.sv ***
// plane memory model answering translated frame-buffer reads
`timescale 1ns/10ps
module vgm_plane_model (
  input  wire logic        clk,
  input  wire logic        fbGo,
  input  wire logic        fbWrite,
  input  wire logic [22:0] fbAddrOut,
  input  wire logic [1:0]  lag,
  output logic             planeRdValid,
  output logic      [31:0] planeRdData
);
  logic        pend = 1'b0;
  logic [1:0]  cnt = 2'h0;
  logic [31:0] held = 32'h0;
  initial planeRdValid = 1'b0;
  initial planeRdData = 32'h0;
  // idle bus toggles so a stale byte can never pass for a return
  always @(posedge clk) begin
    if (pend && cnt == 2'h0) begin
      planeRdValid <= 1'b1;
      planeRdData <= held;
      pend = 1'b0;
    end else begin
      planeRdValid <= 1'b0;
      planeRdData <= ~planeRdData;
      if (pend) cnt = cnt - 2'h1;
    end
    if (fbGo === 1'b1 && fbWrite === 1'b0) begin
      pend = 1'b1;
      cnt = lag;
      held = {4{fbAddrOut[7:0]}} ^ 32'h3c5aa500;
    end
  end
endmodule : vgm_plane_model

// *** verification/vgm_graphics_map_test.sv ***
// self-checking bench for the graphics mapping register bank
`timescale 1ns/10ps
`define CHK(n, e, s) begin checks++; if ((e) !== (s)) begin fails++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module vgm_graphics_map_test
  import vgm_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, ioWrite = 1'b0, ioRead = 1'b0, fbReq = 1'b0, fbWe = 1'b0;
  logic gfxRangeIn = 1'b0, prefetchDisable = 1'b0, readModeOne = 1'b0;
  logic [15:0] ioAddr = 16'h0000;
  logic [7:0]  ioWrData = 8'h00, ioRdData, cpuRdData;
  logic [19:0] fbAddrIn = 20'h00000;
  logic [31:0] fbWrPreMask = 32'h0, planeRdData, fbWrData, lat = 32'h0;
  logic [3:0]  seqPlaneMask = 4'h0, colorCompare = 4'h0, fbPlaneEn;
  logic [1:0]  readPlaneSel = 2'h0, lag = 2'h0;
  logic [22:0] fbAddrOut;
  logic ioRdValid, planeRdValid, fbGo, fbWrite, fbVgaXlate, fbPaged, fbToLocal, fbMemMap;
  logic fbPackedXlate, fbNeedTable, fbPrefetch, cpuRdValid, graphicsMode;
  logic [7:0]  misc = MISC_RESET, ign = IGNORE_RESET, msk = BITMASK_RESET;
  logic [7:0]  amc = AMC_RESET, pg = PAGE_RESET;
  logic [7:0]  scr [SCR_COUNT] = '{default: SCR_RESET};
  logic [7:0]  rq[$], cq[$];
  logic [65:0] fq[$];
  int checks = 0, fails = 0;

  always #20 clk = ~clk;

  vgm_graphics_map dut (.clk, .rst_n, .ioWrite, .ioRead, .ioAddr, .ioWrData, .ioRdData,
    .ioRdValid, .fbReq, .fbWe, .fbAddrIn, .gfxRangeIn, .prefetchDisable, .fbWrPreMask,
    .seqPlaneMask, .planeRdValid, .planeRdData, .readModeOne, .readPlaneSel, .colorCompare,
    .fbGo, .fbWrite, .fbAddrOut, .fbPlaneEn, .fbWrData, .fbVgaXlate, .fbPaged, .fbToLocal,
    .fbMemMap, .fbPackedXlate, .fbNeedTable, .fbPrefetch, .cpuRdData, .cpuRdValid,
    .graphicsMode);
  vgm_plane_model pm (.clk, .fbGo, .fbWrite, .fbAddrOut, .lag, .planeRdValid, .planeRdData);

  function automatic logic [7:0] ev(input logic [7:0] i);
    case (i)
      IDX_MISC: ev = misc;
      IDX_IGNORE: ev = ign;
      IDX_BITMASK: ev = msk;
      IDX_AMC: ev = amc;
      IDX_PAGE: ev = pg;
      default: ev = (i >= IDX_SCR_FIRST && i <= IDX_SCR_LAST) ? scr[4'(i - IDX_SCR_FIRST)] : 8'h00;
    endcase
  endfunction : ev

  task automatic reg_wr(input logic [7:0] i, input logic [7:0] d);
    @(posedge clk) #1;
    ioWrite = 1'b1; ioAddr = IO_INDEX_ADDR; ioWrData = i;
    @(posedge clk) #1;
    ioAddr = IO_DATA_ADDR; ioWrData = d;
    @(posedge clk) #1;
    ioWrite = 1'b0;
    case (i)
      IDX_MISC: misc = d & MISC_WR_MASK;
      IDX_IGNORE: ign = d & IGNORE_WR_MASK;
      IDX_BITMASK: msk = d;
      IDX_AMC: amc = d & AMC_WR_MASK;
      IDX_PAGE: pg = d;
      default: if (i >= IDX_SCR_FIRST && i <= IDX_SCR_LAST) scr[4'(i - IDX_SCR_FIRST)] = d;
    endcase
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] i, input logic [7:0] e, input logic [15:0] p);
    @(posedge clk) #1;
    ioWrite = 1'b1; ioAddr = IO_INDEX_ADDR; ioWrData = i;
    @(posedge clk) #1;
    ioWrite = 1'b0; ioRead = 1'b1; ioAddr = p; rq.push_back(e);
    @(posedge clk) #1;
    ioRead = 1'b0;
  endtask : reg_rd

  // expectation built from the shadow registers; reads also refresh the shadow latches
  task automatic fb(input logic [19:0] a, input logic w);
    logic [16:0] o; logic [3:0] pe; logic hit, byp, pd; logic [22:0] ad;
    logic [31:0] pre, p; logic [7:0] cb; logic [1:0] m;
    m = misc[3:2]; byp = amc[1] | amc[2]; pre = $urandom;
    hit = m == 2'd0 ? a[19:17] == SEG_A_TO_B : m == 2'd1 ? a[19:16] == SEG_A :
          m == 2'd2 ? a[19:15] == SEG_B0 : a[19:15] == SEG_B8;
    o = m == 2'd0 ? a[16:0] : m == 2'd1 ? {1'b0, a[15:0]} : {2'b0, a[14:0]};
    pe = byp ? ALL_PLANES : seqPlaneMask;
    if (misc[1] && !byp) begin
      o = {o[0], o[15:1], o[16]}; pe = a[0] ? ODD_PLANES : EVEN_PLANES;
    end
    pd = amc[0] && a[19:16] == SEG_A;
    ad = pd ? {pg[6:0], o[15:0]} : {6'h0, o};
    @(posedge clk) #1;
    fbReq = 1'b1; fbWe = w; fbAddrIn = a; fbWrPreMask = pre;
    readPlaneSel = 2'($urandom); lag = 2'($urandom % 3);
    if (hit) begin
      fq.push_back({misc[0], amc[3], amc[2], w, ad, pe, !byp, pd, pd & byp & !amc[3] & amc[4],
                    (pre & {4{msk}}) | (lat & ~{4{msk}})});
      if (!w) begin
        p = {4{ad[7:0]}} ^ 32'h3c5aa500; lat = p; cb = 8'hff;
        for (int k = 0; k < 32; k++) if (ign[k/8] && p[k] !== colorCompare[k/8]) cb[k%8] = 1'b0;
        cq.push_back(readModeOne ? cb : p[8*readPlaneSel +: 8]);
      end
    end
    @(posedge clk) #1;
    fbReq = 1'b0;
    if (!w) repeat (8) @(posedge clk) #1;
  endtask : fb

  task automatic gfx(input logic pd);
    @(posedge clk) #1;
    fbReq = 1'b1; fbWe = 1'b1; gfxRangeIn = 1'b1; prefetchDisable = pd; fbAddrIn = 20'($urandom);
    @(posedge clk) #1;
    fbReq = 1'b0; gfxRangeIn = 1'b0;
  endtask : gfx

  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim

  // notes are popped once into locals, the macro reads its arguments twice
  always @(posedge clk) if (rst_n) begin
    logic [65:0] f;
    logic [7:0]  r;
    if (ioRdValid === 1'b1) begin
      r = rq.pop_front();
      `CHK("regRead", r, ioRdData)
    end
    if (fbGo === 1'b1 && fbNeedTable !== 1'b1) begin
      f = fq.pop_front();
      `CHK("fbAccess", f[61:32], {fbAddrOut, fbPlaneEn, fbVgaXlate, fbPaged, fbToLocal})
      `CHK("fbWrite", f[62], fbWrite)
      `CHK("fbMode", f[65:63], {graphicsMode, fbMemMap, fbPackedXlate})
      if (f[62]) `CHK("fbData", f[31:0], fbWrData)
    end
    if (cpuRdValid === 1'b1) begin
      r = cq.pop_front();
      `CHK("cpuRead", r, cpuRdData)
    end
  end

  initial begin
    #400000;
    fails++;
    end_sim();
  end

  initial begin
    void'($urandom(24389));
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int i = 5; i <= 32; i++) begin
      reg_rd(8'(i), ev(8'(i)), IO_DATA_ADDR);
      reg_wr(8'(i), 8'($urandom));
      reg_rd(8'(i), ev(8'(i)), IO_DATA_ADDR);
      reg_rd(8'(i), 8'(i), IO_INDEX_ADDR);
    end
    reg_wr(IDX_AMC, 8'h00);
    for (int i = 0; i < 16; i++) begin
      reg_wr(IDX_MISC, 8'(i));
      seqPlaneMask = 4'($urandom);
      fb({4'ha, 16'($urandom)}, 1'b0);
      reg_wr(IDX_BITMASK, 8'($urandom));
      fb({4'ha, 16'($urandom)}, 1'b1);
      fb({5'h16, 15'($urandom)}, 1'b1);
      fb({5'h17, 15'($urandom)}, 1'b1);
      fb({4'hc, 16'($urandom)}, 1'b1);
    end
    readModeOne = 1'b1;
    for (int i = 0; i < 16; i++) begin
      reg_wr(IDX_IGNORE, 8'(i | 8'hf0));
      colorCompare = 4'($urandom);
      fb({4'ha, 16'($urandom)}, 1'b0);
    end
    readModeOne = 1'b0;
    for (int i = 0; i < 32; i++) begin
      reg_wr(IDX_MISC, 8'($urandom) & 8'h03);
      reg_wr(IDX_PAGE, 8'($urandom));
      reg_wr(IDX_AMC, 8'(i) | 8'he0);
      fb({4'ha, 16'($urandom)}, 1'b1);
      fb({4'hb, 16'($urandom)}, 1'b0);
    end
    reg_wr(IDX_MISC, 8'h00);
    reg_wr(IDX_PAGE, 8'h00);
    reg_wr(IDX_AMC, 8'h17);
    fb({4'ha, 16'($urandom)}, 1'b1);
    gfx(1'b0);
    gfx(1'b1);
    repeat (12) @(posedge clk);
    `CHK("leftover", 0, rq.size() + fq.size() + cq.size())
    end_sim();
  end
endmodule : vgm_graphics_map_test
